/* File: rtl/cad_pkg.sv */
package cad_pkg;
  // Pin mapping codes
  localparam logic [1:0] CAD_MAP_PRIMARY = 2'h0;
  localparam logic [1:0] CAD_MAP_ALT_A = 2'h1;
  localparam logic [1:0] CAD_MAP_ALT_B = 2'h2;
  localparam logic [1:0] CAD_MAP_NONE = 2'h3;
  // Field positions inside the two pin-mapping configuration words
  localparam int CAD_MAP1_PIN0_POS = 6;
  localparam int CAD_MAP1_PIN1_POS = 4;
  localparam int CAD_MAP1_PIN2_POS = 2;
  localparam int CAD_MAP1_PIN3_POS = 0;
  localparam int CAD_MAP2_PIN4_POS = 6;
  localparam int CAD_MAP2_PIN5_POS = 4;
  // Status bit positions
  localparam int CAD_STAT_DETECT_POS = 0;
  localparam int CAD_STAT_SYNC_POS = 1;
  localparam int CAD_STAT_HDR_POS = 3;
  // Scan timing: receive window of (2^SF + 32) chips; one chip per
  // chip_tick from the modem timebase
  localparam logic [12:0] CAD_RX_EXTRA_CHIPS = 13'h0020;
  localparam logic [12:0] CAD_PROC_MARGIN_CHIPS = 13'h0010;
  localparam logic [7:0] CAD_MAP_RESET = 8'h00;

  typedef enum logic [4:0] {
    CAD_IDLE = 5'b00001,
    CAD_LOCK = 5'b00010,
    CAD_CAPTURE = 5'b00100,
    CAD_CORRELATE = 5'b01000,
    CAD_DONE = 5'b10000
  } cad_state_type;
endpackage : cad_pkg

/* File: rtl/cad_event_map.sv */
module cad_event_map
  import cad_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scan_start,
  input wire logic [3:0] spread_factor,
  input wire logic chip_tick,
  input wire logic synth_locked,
  input wire logic corr_match,
  input wire logic [7:0] pin_map_first,
  input wire logic [7:0] pin_map_second,
  input wire logic clock_output,
  input wire logic op_state_settled_in,
  input wire logic hop_channel_request,
  input wire logic receive_window_expired,
  input wire logic receive_complete,
  input wire logic transmit_complete,
  input wire logic header_accepted,
  input wire logic payload_check_fail,
  input wire logic preamble_found,
  input wire logic demod_locked,
  output logic rx_power_en,
  output logic synth_power_en,
  output logic capture_en,
  output logic correlate_en,
  output logic scan_busy,
  output logic standby_req,
  output logic activity_scan_finished,
  output logic activity_scan_hit,
  output logic [7:0] demod_state_reg,
  output logic event_pin_0,
  output logic event_pin_1,
  output logic event_pin_2,
  output logic event_pin_3,
  output logic event_pin_4,
  output logic event_pin_5
);

  cad_state_type state;
  cad_state_type next_state;
  logic [12:0] chip_cnt;
  logic [12:0] next_chip_cnt;
  logic [7:0] next_demod;
  logic [5:0] next_pins;

  // One symbol is 2^SF chips; SF limited to 12 so the window fits 13 bits
  function automatic logic [12:0] sym_chips(input logic [3:0] sf);
    logic [3:0] s;
    s = (sf > 4'hC) ? 4'hC : sf;
    sym_chips = 13'h0001 << s;
  endfunction : sym_chips

  function automatic logic map_sel(input logic [1:0] code, input logic a,
                                   input logic b, input logic c);
    unique case (code)
      CAD_MAP_PRIMARY: map_sel = a;
      CAD_MAP_ALT_A: map_sel = b;
      CAD_MAP_ALT_B: map_sel = c;
      CAD_MAP_NONE: map_sel = 1'b0;
    endcase
  endfunction : map_sel

  wire logic [12:0] rx_window = sym_chips(spread_factor) + CAD_RX_EXTRA_CHIPS;
  // Correlation ends a margin before a full symbol
  wire logic [12:0] proc_window = sym_chips(spread_factor) - CAD_PROC_MARGIN_CHIPS;
  wire logic cap_end = (state == CAD_CAPTURE) && chip_tick && (chip_cnt >= rx_window - 13'h0001);
  wire logic corr_end = (state == CAD_CORRELATE) && chip_tick
                        && (chip_cnt >= proc_window - 13'h0001);

  always_comb begin
    next_state = state;
    next_chip_cnt = chip_cnt;
    unique case (state)
      CAD_IDLE: if (scan_start) next_state = CAD_LOCK;
      CAD_LOCK: begin
        next_chip_cnt = 13'h0000;
        if (synth_locked) next_state = CAD_CAPTURE;
      end
      CAD_CAPTURE: begin
        if (cap_end) begin
          next_state = CAD_CORRELATE;
          next_chip_cnt = 13'h0000;
        end else if (chip_tick) begin
          next_chip_cnt = chip_cnt + 13'h0001;
        end
      end
      CAD_CORRELATE: begin
        if (corr_end) next_state = CAD_DONE;
        else if (chip_tick) next_chip_cnt = chip_cnt + 13'h0001;
      end
      CAD_DONE: next_state = CAD_IDLE;
      default: next_state = CAD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= CAD_IDLE;
      chip_cnt <= 13'h0000;
    end else begin
      state <= next_state;
      chip_cnt <= next_chip_cnt;
    end
  end

  // Receiver and synthesizer only run until capture ends; correlation is low power
  assign synth_power_en = (state == CAD_LOCK) || (state == CAD_CAPTURE);
  assign rx_power_en = (state == CAD_CAPTURE);
  assign capture_en = (state == CAD_CAPTURE);
  assign correlate_en = (state == CAD_CORRELATE);
  assign scan_busy = (state != CAD_IDLE);
  assign standby_req = (state == CAD_DONE);

  // Pulses last one cycle; the host keeps its own pending flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      activity_scan_finished <= 1'b0;
      activity_scan_hit <= 1'b0;
    end else begin
      activity_scan_finished <= corr_end;
      activity_scan_hit <= corr_end && corr_match;
    end
  end

  always_comb begin
    next_demod = 8'h00;
    next_demod[CAD_STAT_DETECT_POS] = preamble_found;
    next_demod[CAD_STAT_SYNC_POS] = preamble_found && demod_locked;
    next_demod[CAD_STAT_HDR_POS] = header_accepted;
  end

  wire logic [1:0] code0 = pin_map_first[CAD_MAP1_PIN0_POS +: 2];
  wire logic [1:0] code1 = pin_map_first[CAD_MAP1_PIN1_POS +: 2];
  wire logic [1:0] code2 = pin_map_first[CAD_MAP1_PIN2_POS +: 2];
  wire logic [1:0] code3 = pin_map_first[CAD_MAP1_PIN3_POS +: 2];
  wire logic [1:0] code4 = pin_map_second[CAD_MAP2_PIN4_POS +: 2];
  wire logic [1:0] code5 = pin_map_second[CAD_MAP2_PIN5_POS +: 2];

  // Pins reflect registered scan events so the scan pulses and pin move together
  assign next_pins[0] = map_sel(code0, receive_complete, transmit_complete,
                                corr_end);
  assign next_pins[1] = map_sel(code1, receive_window_expired, hop_channel_request,
                                corr_end && corr_match);
  assign next_pins[2] = map_sel(code2, hop_channel_request, hop_channel_request,
                                hop_channel_request);
  assign next_pins[3] = map_sel(code3, corr_end, header_accepted,
                                payload_check_fail);
  assign next_pins[4] = map_sel(code4, corr_end && corr_match, synth_locked,
                                synth_locked);
  assign next_pins[5] = map_sel(code5, op_state_settled_in, clock_output,
                                clock_output);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      demod_state_reg <= 8'h00;
      {event_pin_5, event_pin_4, event_pin_3, event_pin_2, event_pin_1, event_pin_0} <= 6'h00;
    end else begin
      demod_state_reg <= next_demod;
      {event_pin_5, event_pin_4, event_pin_3, event_pin_2, event_pin_1, event_pin_0} <= next_pins;
    end
  end

  sequence s_corr_done;
    correlate_en && chip_tick && (chip_cnt >= proc_window - 13'h0001);
  endsequence

  AST_HIT_WITH_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    activity_scan_hit |-> activity_scan_finished)
    else $error("scan hit without scan finished");
  AST_DONE_AFTER_CORR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_corr_done |=> activity_scan_finished && (activity_scan_hit == $past(corr_match)))
    else $error("scan finished not raised after correlation");
  AST_STANDBY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_corr_done |=> standby_req ##1 !scan_busy)
    else $error("no return to standby");
  AST_RX_OFF_CORR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    correlate_en |-> !rx_power_en && !synth_power_en)
    else $error("receiver powered during correlation");
  AST_LOCK_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rx_power_en) |-> $past(synth_power_en) && $past(synth_locked))
    else $error("capture started before lock");
  AST_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!scan_busy && scan_start) |=> synth_power_en)
    else $error("scan did not start");
  AST_MAP_NONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (code0 == CAD_MAP_NONE) |=> !event_pin_0)
    else $error("unmapped pin not low");
  AST_PIN3_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (code3 == CAD_MAP_PRIMARY) |=> (event_pin_3 == activity_scan_finished))
    else $error("pin 3 does not follow scan finished");
  AST_PIN4_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (code4 == CAD_MAP_ALT_A) |=> (event_pin_4 == $past(synth_locked)))
    else $error("pin 4 does not follow lock");
  AST_STATUS_HDR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    header_accepted |=> demod_state_reg[CAD_STAT_HDR_POS])
    else $error("header status bit missing");
  AST_STATUS_DET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    preamble_found |=> demod_state_reg[CAD_STAT_DETECT_POS])
    else $error("preamble status bit missing");
  AST_STATUS_SYNC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (preamble_found && demod_locked) |=> demod_state_reg[CAD_STAT_SYNC_POS])
    else $error("lock status bit missing");
  AST_PIN0_FIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (code0 == CAD_MAP_ALT_B) |=> (event_pin_0 == activity_scan_finished))
    else $error("pin 0 does not follow scan finished");
  AST_PIN2_HOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (code2 != CAD_MAP_NONE) |=> (event_pin_2 == $past(hop_channel_request)))
    else $error("pin 2 does not follow hop request");

endmodule : cad_event_map

/* File: tb/cad_host_model.sv */
// Far side stand-ins: host pending flags, modem timebase and synthesizer lock
module cad_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic done_pin,
  input wire logic hit_pin,
  input wire logic clear_flags,
  output logic done_flag,
  output logic hit_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pending flags latch the event pins; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
      hit_flag <= 1'b0;
    end else begin
      done_flag <= done_pin || (done_flag && !clear_flags);
      hit_flag <= hit_pin || (hit_flag && !clear_flags);
    end
  end
endmodule : cad_host_model

module cad_synth_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic synth_power_en,
  output logic chip_tick,
  output logic synth_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  logic [2:0] lock_cnt;
  // A chip every second cycle, so tick counts and cycle counts differ
  assign chip_tick = div[0];
  // Lock drops one cycle after power goes, never held from an earlier scan
  assign synth_locked = (lock_cnt == 3'h4);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div <= 2'h0;
      lock_cnt <= 3'h0;
    end else begin
      div <= div + 2'h1;
      lock_cnt <= !synth_power_en ? 3'h0 : (synth_locked ? lock_cnt : lock_cnt + 3'h1);
    end
  end
endmodule : cad_synth_model

/* File: tb/cad_event_map_tb.sv */
module cad_event_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic scan_start = 1'h0;
  logic corr_match = 1'h0;
  logic [7:0] pin_map_first = 8'h00;
  logic [7:0] pin_map_second = 8'h00;
  logic [9:0] src = 10'h000;
  logic [3:0] spread_factor = 4'h5;
  logic clear_flags = 1'h0;
  logic done_flag, hit_flag;
  logic [5:0] pins;
  logic [7:0] demod_state_reg;
  logic chip_tick, synth_locked, rx_power_en, synth_power_en, capture_en, correlate_en;
  logic scan_busy, standby_req, activity_scan_finished, activity_scan_hit;
  int miscompares = 0;
  int total_checks = 0;
  always #20 sys_clk = ~sys_clk;

  cad_synth_model i_cad_synth_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .synth_power_en(synth_power_en), .chip_tick(chip_tick), .synth_locked(synth_locked));
  cad_event_map i_cad_event_map (.sys_clk(sys_clk), .rst_n(rst_n), .scan_start(scan_start),
    .spread_factor(spread_factor), .chip_tick(chip_tick), .synth_locked(synth_locked),
    .corr_match(corr_match), .pin_map_first(pin_map_first), .pin_map_second(pin_map_second),
    .clock_output(src[0]), .op_state_settled_in(src[1]), .hop_channel_request(src[2]),
    .receive_window_expired(src[3]), .receive_complete(src[4]), .transmit_complete(src[5]),
    .header_accepted(src[6]), .payload_check_fail(src[7]), .preamble_found(src[8]),
    .demod_locked(src[9]), .rx_power_en(rx_power_en), .synth_power_en(synth_power_en),
    .capture_en(capture_en), .correlate_en(correlate_en), .scan_busy(scan_busy),
    .standby_req(standby_req), .activity_scan_finished(activity_scan_finished),
    .activity_scan_hit(activity_scan_hit), .demod_state_reg(demod_state_reg),
    .event_pin_0(pins[0]), .event_pin_1(pins[1]), .event_pin_2(pins[2]),
    .event_pin_3(pins[3]), .event_pin_4(pins[4]), .event_pin_5(pins[5]));
  cad_host_model i_cad_host_model (.sys_clk(sys_clk), .rst_n(rst_n), .done_pin(pins[3]),
    .hit_pin(pins[4]), .clear_flags(clear_flags), .done_flag(done_flag), .hit_flag(hit_flag));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    total_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Idle scan events are low, so hit and finished sources read as zero here
  function automatic logic [5:0] exp_pins(input logic [1:0] c, input logic [9:0] s,
                                          input logic lk);
    case (c)
      2'h0: return {s[1], 2'h0, s[2], s[3], s[4]};
      2'h1: return {s[0], lk, s[6], s[2], s[2], s[5]};
      2'h2: return {s[0], lk, s[7], s[2], 2'h0};
      default: return 6'h00;
    endcase
  endfunction : exp_pins

  // Scan: 2^sf+32 chips listening, 2^sf-16 chips correlating
  // Pin map A0: pins 0 and 1 on code 10, the others on code 00
  task automatic run_scan(input logic m, input logic [3:0] sf);
    int rxc, cpc, coc, n, exp_rx, exp_co;
    rxc = 0;
    cpc = 0;
    coc = 0;
    n = 0;
    exp_rx = (1 << sf) + 32;
    exp_co = (1 << sf) - 16;
    check("flags_idle", {6'h00, hit_flag, done_flag}, 8'h00);
    spread_factor = sf;
    corr_match = m;
    scan_start = 1'h1;
    @(negedge sys_clk);
    scan_start = 1'h0;
    check("synth_on", {7'h00, synth_power_en}, 8'h01);
    check("rx_before_lock", {7'h00, rx_power_en}, 8'h00);
    while (activity_scan_finished !== 1'h1 && n < 3000) begin
      if (chip_tick && rx_power_en) rxc++;
      if (chip_tick && capture_en) cpc++;
      if (chip_tick && correlate_en) coc++;
      check("power_in_corr", {6'h00, correlate_en & rx_power_en,
            correlate_en & synth_power_en}, 8'h00);
      n++;
      @(negedge sys_clk);
    end
    check("finished", {7'h00, activity_scan_finished}, 8'h01);
    check("hit", {7'h00, activity_scan_hit}, {7'h00, m});
    check("standby", {7'h00, standby_req}, 8'h01);
    check("rx_ticks", rxc[7:0], exp_rx[7:0]);
    check("capture_ticks", cpc[7:0], exp_rx[7:0]);
    check("corr_ticks", coc[7:0], exp_co[7:0]);
    check("scan_pins", {2'h0, pins}, {3'h0, m, 1'h1, 1'h0, m, 1'h1});
    @(negedge sys_clk);
    check("busy", {7'h00, scan_busy}, 8'h00);
    check("scan_pins_end", {2'h0, pins}, 8'h00);
    check("flags_set", {6'h00, hit_flag, done_flag}, {6'h00, m, 1'h1});
    clear_flags = 1'h1;
    @(negedge sys_clk);
    clear_flags = 1'h0;
    check("flags_clear", {6'h00, hit_flag, done_flag}, 8'h00);
  endtask : run_scan

  initial begin
    logic [1:0] cd;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'h1;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 11; i++) begin
        cd = c[1:0];
        pin_map_first = {cd, cd, cd, cd};
        pin_map_second = {cd, cd, 4'h0};
        src = (i < 10) ? (10'h001 << i) : 10'h3ff;
        repeat (2) @(negedge sys_clk);
        check("pins", {2'h0, pins}, {2'h0, exp_pins(cd, src, synth_locked)});
        check("status", demod_state_reg, {4'h0, src[6], 1'h0, src[8] & src[9], src[8]});
      end
    end
    pin_map_first = 8'hA0;
    pin_map_second = 8'h00;
    src = 10'h000;
    clear_flags = 1'h1;
    @(negedge sys_clk);
    clear_flags = 1'h0;
    run_scan(1'h1, 4'h5);
    run_scan(1'h0, 4'h5);
    run_scan(1'h1, 4'h6);
    wrap_up();
  end

  // About 44 mapping steps and three scans of at most some 300 cycles each
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end
endmodule : cad_event_map_tb
